// >>> core/reset_source_and_startup_control.sv
// reset source and start-up control: combines reset sources, orders start-up,
// keeps sticky cause flags. assumes core events are single-cycle pulses on ref_clk.
//
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module reset_source_and_startup_control
  import rst_pkg::*;
#(
  parameter int STARTUP_CYCLES = STARTUP_DELAY_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire rst_pkg::cfg_s cfg,
  input wire rst_pkg::event_s ev,
  input wire logic global_irq_enable,
  input wire logic [15:0] pc,
  input wire logic external_reset_pin_in,
  output logic external_reset_pin_out,
  output logic external_reset_pin_oe,
  output logic pin_pullup_en,
  output logic gpio_in,
  output logic device_reset,
  output logic cpu_run,
  output logic [15:0] restart_addr,
  output logic bandgap_force_on,
  output logic brownout_enable,
  input wire logic brownout_circuit_active,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hsel,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);
  import rst_pkg::*;

  // ************************************************************
  // elaboration checks
  // ************************************************************
  // counters below are sized for these ranges
  if (STARTUP_CYCLES < 1) begin : g_bad_startup
    $error("STARTUP_CYCLES must be at least 1");
  end
  if (PIN_FILTER_CYCLES < 2 || PIN_FILTER_CYCLES > 16) begin : g_bad_filter
    $error("PIN_FILTER_CYCLES must be 2 to 16");
  end
  if (PIN_RELEASE_CYCLES < 1 || PIN_RELEASE_CYCLES > 16) begin : g_bad_release
    $error("PIN_RELEASE_CYCLES must be 1 to 16");
  end

  // ************************************************************
  // register state
  // ************************************************************
  logic sw_brownout_enable;
  logic brownout_fast_start;
  logic stack_over_flag, stack_under_flag;
  logic watchdog_reset_flag_n, pin_reset_flag_n, soft_restart_flag_n;
  logic por_flag_n, brownout_flag_n;
  logic watchdog_expiry_n, sleep_entry_n;
  logic pullup_sw;

  // ************************************************************
  // brown-out control
  // ************************************************************
  always_comb begin
    // unlisted codes fall to always-on, the safe side
    case (cfg.brownout_mode_cfg)
      MODE_SW: brownout_enable = sw_brownout_enable;
      MODE_OFF: brownout_enable = 1'b0;
      MODE_SLEEP_OFF: brownout_enable = !ev.sleeping;
      default: brownout_enable = 1'b1;
    endcase
  end
  assign bandgap_force_on = brownout_fast_start &&
    (cfg.brownout_mode_cfg == MODE_SW || cfg.brownout_mode_cfg == MODE_SLEEP_OFF);

  // ************************************************************
  // brown-out detectors
  // ************************************************************
  logic lp_req, bor_req, bor_any;
  assign lp_req = cfg.low_power_brownout && ev.lp_brownout_low;
  assign bor_req = brownout_enable && ev.brownout_low;
  assign bor_any = bor_req || lp_req;

  // ************************************************************
  // external pin path
  // ************************************************************
  logic pin_en;
  assign pin_en = cfg.low_voltage_program_cfg || cfg.external_pin_cfg_enable;
  assign external_reset_pin_out = 1'b0;
  assign external_reset_pin_oe = 1'b0;
  assign pin_pullup_en = pin_en ? 1'b1 : pullup_sw;

  // three stages: only the settled second and third are compared
  logic [2:0] pin_sync;
  always_ff @(posedge ref_clk) begin
    if (rst) pin_sync <= 3'b111;
    else pin_sync <= {pin_sync[1:0], external_reset_pin_in};
  end
  assign gpio_in = pin_sync[2];

  // ************************************************************
  // pin noise filter
  // ************************************************************
  // filter: low must persist PIN_FILTER_CYCLES to count
  logic pin_low;
  logic [3:0] filt_cnt;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      filt_cnt <= '0;
      pin_low <= 1'b0;
    end else if (pin_sync[1] != pin_sync[2]) begin
      filt_cnt <= '0;
    end else if ((!pin_sync[2]) == pin_low) begin
      filt_cnt <= '0;
    end else if (filt_cnt == 4'(PIN_FILTER_CYCLES - 1)) begin
      filt_cnt <= '0;
      pin_low <= !pin_sync[2];
    end else begin
      filt_cnt <= filt_cnt + 4'h1;
    end
  end
  logic pin_hold;
  assign pin_hold = pin_en && pin_low;

  // ************************************************************
  // reset sources
  // ************************************************************
  logic por_ev, stk_ev, core_rst_ev, bor_prev, bor_rise, pin_prev, pin_ev;
  assign por_ev = ev.power_on || ev.prog_exit;
  assign stk_ev = cfg.stack_fault_reset_cfg && (ev.stack_over || ev.stack_under);
  // a time-out while sleeping is a wake, not a reset
  assign core_rst_ev = (ev.watchdog_timeout && !ev.sleeping) || ev.reset_instr
    || stk_ev;
  // edge detectors rest low, matching idle causes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bor_prev <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      bor_prev <= bor_any;
      pin_prev <= pin_hold;
    end
  end
  assign bor_rise = bor_any && !bor_prev;
  assign pin_ev = pin_hold && !pin_prev;

  // ************************************************************
  // start-up sequencer
  // ************************************************************
  seq_e state;
  logic [31:0] delay_cnt;
  logic [3:0] rel_cnt;
  logic timers_done;
  // oscillator wait only where the clock source needs one
  assign timers_done = (delay_cnt == '0) &&
    (ev.osc_ready || !cfg.osc_startup_required);

  // delay counts independent of pin level
  always_ff @(posedge ref_clk) begin
    if (rst || por_ev || bor_any) begin
      delay_cnt <= cfg.startup_delay_cfg_n ? '0 : 32'(STARTUP_CYCLES);
    end else if (delay_cnt != '0) begin
      delay_cnt <= delay_cnt - 32'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || por_ev || bor_any) begin
      state <= ST_HELD;
      rel_cnt <= '0;
    end else begin
      case (state)
        ST_HELD: begin
          if (timers_done) begin
            state <= pin_hold ? ST_WAIT_PIN : ST_RUN;
          end
        end
        ST_WAIT_PIN: begin
          if (!pin_hold) begin
            state <= ST_RELEASE;
            rel_cnt <= '0;
          end
        end
        ST_RELEASE: begin
          if (pin_hold) state <= ST_WAIT_PIN;
          else if (rel_cnt == 4'(PIN_RELEASE_CYCLES - 1)) state <= ST_RUN;
          else rel_cnt <= rel_cnt + 4'h1;
        end
        ST_RUN: begin
          if (pin_hold || core_rst_ev) state <= ST_WAIT_PIN;
        end
        default: state <= ST_HELD;
      endcase
    end
  end
  // reset asserts the same cycle the cause appears
  assign device_reset = (state != ST_RUN) ||
    por_ev ||
    bor_any ||
    pin_hold ||
    core_rst_ev;
  assign cpu_run = !device_reset;

  // ************************************************************
  // restart address
  // ************************************************************
  // wakes resume at pc+1, an irq wake with global_irq_enable at IRQ_VECTOR; any reset goes to the vector
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      restart_addr <= RESET_VECTOR;
    end else if (por_ev || bor_any || pin_ev || core_rst_ev) begin
      restart_addr <= RESET_VECTOR;
    end else if (ev.irq_wake) begin
      restart_addr <= global_irq_enable ? IRQ_VECTOR : pc + 16'h1;
    end else if (ev.watchdog_timeout && ev.sleeping) begin
      restart_addr <= pc + 16'h1;
    end
  end

  // ************************************************************
  // cause flags; hardware events win over software writes
  // ************************************************************
  logic wr_pend;
  logic [7:0] wr_addr;
  logic bus_wr;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end else if (hready) begin
      wr_pend <= hsel && htrans[1] && hwrite;
      wr_addr <= haddr[7:0];
    end
  end
  assign bus_wr = wr_pend;


  // ************************************************************
  // flag update; set events override the write below
  // ************************************************************
  logic wdt_rst, wdt_wake;
  assign wdt_rst = ev.watchdog_timeout && !ev.sleeping;
  assign wdt_wake = ev.watchdog_timeout && ev.sleeping;

  always_ff @(posedge ref_clk) begin
    if (rst || por_ev) begin
      {stack_over_flag, stack_under_flag} <= 2'b00;
      {watchdog_reset_flag_n, pin_reset_flag_n, soft_restart_flag_n} <= 3'b111;
      por_flag_n <= 1'b0;
      brownout_flag_n <= 1'b0;
      watchdog_expiry_n <= 1'b1;
      sleep_entry_n <= 1'b1;
    end else if (bor_rise) begin
      {stack_over_flag, stack_under_flag} <= 2'b00;
      pin_reset_flag_n <= 1'b1;
      soft_restart_flag_n <= 1'b1;
      brownout_flag_n <= 1'b0;
      watchdog_expiry_n <= 1'b1;
      sleep_entry_n <= 1'b1;
    end else begin
      if (bus_wr && wr_addr == POWER_CONTROL_ADDR) begin
        stack_over_flag <= hwdata[OVF_BIT];
        stack_under_flag <= hwdata[UNF_BIT];
        watchdog_reset_flag_n <= hwdata[WDT_BIT];
        pin_reset_flag_n <= hwdata[PIN_BIT];
        soft_restart_flag_n <= hwdata[RI_BIT];
        por_flag_n <= hwdata[POR_BIT];
        brownout_flag_n <= hwdata[BOR_BIT];
      end
      if (bus_wr && wr_addr == CORE_STATUS_ADDR) begin
        watchdog_expiry_n <= hwdata[EXP_BIT];
        sleep_entry_n <= hwdata[SLP_BIT];
      end
      if (pin_ev) begin
        pin_reset_flag_n <= 1'b0;
        if (ev.sleeping) begin
          watchdog_expiry_n <= 1'b1;
          sleep_entry_n <= 1'b0;
        end
      end
      if (wdt_rst) begin
        watchdog_reset_flag_n <= 1'b0;
        watchdog_expiry_n <= 1'b0;
      end
      if (wdt_wake) begin
        watchdog_expiry_n <= 1'b0;
        sleep_entry_n <= 1'b0;
      end
      if (ev.irq_wake) begin
        watchdog_expiry_n <= 1'b1;
        sleep_entry_n <= 1'b0;
      end
      if (ev.reset_instr) soft_restart_flag_n <= 1'b0;
      if (cfg.stack_fault_reset_cfg && ev.stack_over) stack_over_flag <= 1'b1;
      if (cfg.stack_fault_reset_cfg && ev.stack_under) stack_under_flag <= 1'b1;
    end
  end

  // brown-out control and pull-up survive non-power resets
  always_ff @(posedge ref_clk) begin
    if (rst || por_ev || bor_rise) begin
      sw_brownout_enable <= 1'b1;
      brownout_fast_start <= 1'b0;
      pullup_sw <= 1'b0;
    end else if (bus_wr && wr_addr == BROWNOUT_CONTROL_ADDR) begin
      sw_brownout_enable <= hwdata[SW_EN_BIT];
      brownout_fast_start <= hwdata[FAST_START_BIT];
    end else if (bus_wr && wr_addr == SLEEP_CONTROL_ADDR) begin
      pullup_sw <= hwdata[0];
    end
  end

  // ************************************************************
  // ahb-lite read path, zero wait states
  // ************************************************************
  logic [31:0] rd_word;
  always_comb begin
    rd_word = '0;
    case (haddr[7:0])
      BROWNOUT_CONTROL_ADDR: begin
        rd_word[SW_EN_BIT] = sw_brownout_enable;
        rd_word[FAST_START_BIT] = brownout_fast_start;
        rd_word[READY_BIT] = brownout_circuit_active;
      end
      POWER_CONTROL_ADDR: begin
        rd_word[OVF_BIT] = stack_over_flag;
        rd_word[UNF_BIT] = stack_under_flag;
        rd_word[WDT_BIT] = watchdog_reset_flag_n;
        rd_word[PIN_BIT] = pin_reset_flag_n;
        rd_word[RI_BIT] = soft_restart_flag_n;
        rd_word[POR_BIT] = por_flag_n;
        rd_word[BOR_BIT] = brownout_flag_n;
      end
      CORE_STATUS_ADDR: begin
        rd_word[EXP_BIT] = watchdog_expiry_n;
        rd_word[SLP_BIT] = sleep_entry_n;
      end
      SLEEP_CONTROL_ADDR: rd_word[0] = pullup_sw;
      default: rd_word = '0;
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (rst) hrdata <= '0;
    else if (hready && hsel && htrans[1] && !hwrite) hrdata <= rd_word;
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
endmodule : reset_source_and_startup_control

// >>> core/rst_pkg.sv
// reset source and start-up control: shared constants and carriers
// assumes a single 100 MHz ref_clk domain and an ahb-lite register port
package rst_pkg;
  localparam int CLK_MHZ = 100;
  localparam int STARTUP_DELAY_MS = 64;
  localparam int STARTUP_DELAY_CYCLES = STARTUP_DELAY_MS * 1000 * CLK_MHZ;
  localparam int PIN_RELEASE_CYCLES = 10;
  localparam int PIN_FILTER_CYCLES = 4;
  localparam logic [7:0] BROWNOUT_CONTROL_ADDR = 8'h00;
  localparam logic [7:0] POWER_CONTROL_ADDR = 8'h04;
  localparam logic [7:0] CORE_STATUS_ADDR = 8'h08;
  localparam logic [7:0] SLEEP_CONTROL_ADDR = 8'h0c;
  localparam int SW_EN_BIT = 7;
  localparam int FAST_START_BIT = 6;
  localparam int READY_BIT = 0;
  localparam int OVF_BIT = 7;
  localparam int UNF_BIT = 6;
  localparam int WDT_BIT = 4;
  localparam int PIN_BIT = 3;
  localparam int RI_BIT = 2;
  localparam int POR_BIT = 1;
  localparam int BOR_BIT = 0;
  localparam int EXP_BIT = 4;
  localparam int SLP_BIT = 3;
  localparam logic [1:0] MODE_SW = 2'b01;
  localparam logic [1:0] MODE_OFF = 2'b00;
  localparam logic [1:0] MODE_SLEEP_OFF = 2'b10;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [15:0] IRQ_VECTOR = 16'h0004;
  localparam logic [7:0] PCON_POR_VAL = 8'h1c;

  typedef struct packed {
    logic [1:0] brownout_mode_cfg;
    logic low_power_brownout;
    logic external_pin_cfg_enable;
    logic low_voltage_program_cfg;
    logic stack_fault_reset_cfg;
    logic startup_delay_cfg_n;
    logic osc_startup_required;
  } cfg_s;

  typedef struct packed {
    logic power_on;
    logic prog_exit;
    logic brownout_low;
    logic lp_brownout_low;
    logic watchdog_timeout;
    logic reset_instr;
    logic stack_over;
    logic stack_under;
    logic irq_wake;
    logic sleeping;
    logic osc_ready;
  } event_s;

  typedef enum logic [1:0] {
    ST_HELD, ST_WAIT_PIN, ST_RELEASE, ST_RUN
  } seq_e;
endpackage : rst_pkg

// >>> tb/rst_seq_chk.sv
// checker: port-level properties of the reset sequencer
// assumes one ref_clk domain, rst synchronous active high
`timescale 1ns/1ps
module rst_seq_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire rst_pkg::cfg_s cfg,
  input wire rst_pkg::event_s ev,
  input wire logic global_irq_enable,
  input wire logic external_reset_pin_in,
  input wire logic external_reset_pin_oe,
  input wire logic pin_pullup_en,
  input wire logic device_reset,
  input wire logic cpu_run,
  input wire logic [15:0] restart_addr,
  input wire logic bandgap_force_on,
  input wire logic brownout_enable,
  input wire logic hreadyout,
  input wire logic hresp
);
  import rst_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ****
  // properties
  // ****
  // pin path has sync and filter ahead of the 10-cycle wait
  sequence s_pin_up;
    $rose(external_reset_pin_in) && device_reset
      && (cfg.low_voltage_program_cfg || cfg.external_pin_cfg_enable);
  endsequence
  sequence s_held_10;
    device_reset[*8] ##1 device_reset[*2];
  endsequence
  property p_pin_hold; s_pin_up |=> s_held_10; endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("run began early");
  property p_no_drive; !external_reset_pin_oe; endproperty
  a_no_drive: assert property (p_no_drive) else $error("pin driven");
  property p_pullup;
    cfg.low_voltage_program_cfg || cfg.external_pin_cfg_enable |-> pin_pullup_en;
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up off");
  property p_off;
    cfg.brownout_mode_cfg == MODE_OFF |-> !brownout_enable && !bandgap_force_on;
  endproperty
  a_off: assert property (p_off) else $error("off mode active");
  property p_on; cfg.brownout_mode_cfg == 2'b11 |-> brownout_enable; endproperty
  a_on: assert property (p_on) else $error("always-on mode off");
  property p_run;
    $rose(cpu_run) && (cfg.low_voltage_program_cfg || cfg.external_pin_cfg_enable)
      |-> external_reset_pin_in && $past(external_reset_pin_in);
  endproperty
  a_run: assert property (p_run) else $error("run began with pin low");
  property p_lp;
    cfg.low_power_brownout && ev.lp_brownout_low |-> ##[0:2] device_reset;
  endproperty
  a_lp: assert property (p_lp) else $error("low supply not held");
  property p_restart;
    $fell(device_reset) |-> ##[0:1] restart_addr == RESET_VECTOR;
  endproperty
  a_restart: assert property (p_restart) else $error("bad restart");
  property p_wake;
    ev.irq_wake && ev.sleeping && global_irq_enable && !device_reset
      |-> ##[1:3] restart_addr == IRQ_VECTOR;
  endproperty
  a_wake: assert property (p_wake) else $error("no irq vector");
  property p_bus; hreadyout && !hresp; endproperty
  a_bus: assert property (p_bus) else $error("bus not okay");
endmodule : rst_seq_chk

bind reset_source_and_startup_control rst_seq_chk u_chk (.ref_clk, .rst, .cfg, .ev,
  .global_irq_enable, .external_reset_pin_in, .external_reset_pin_oe, .pin_pullup_en,
  .device_reset, .cpu_run, .restart_addr, .bandgap_force_on, .brownout_enable,
  .hreadyout, .hresp);

// >>> tb/supply_pin_model.sv
// partner: reset pin driver and supply monitors
// assumes the bench calls its tasks from one process at a time
`timescale 1ns/1ps
module supply_pin_model (
  input wire logic ref_clk,
  input wire logic brownout_enable,
  output logic pin,
  output logic bo_low,
  output logic lp_low,
  output logic active
);
  // ****
  // far side
  // ****
  initial begin
    pin = 1'b1;
    bo_low = 1'b0;
    lp_low = 1'b0;
  end
  // weak pull-up: a released pin reads high
  task automatic hold_pin(input int n);
    @(posedge ref_clk);
    pin <= 1'b0;
    repeat (n) @(posedge ref_clk);
    pin <= 1'b1;
  endtask : hold_pin
  task automatic dip(input logic lp, input int n);
    @(posedge ref_clk);
    if (lp) lp_low <= 1'b1;
    else bo_low <= 1'b1;
    repeat (n) @(posedge ref_clk);
    lp_low <= 1'b0;
    bo_low <= 1'b0;
  endtask : dip
  // circuit settles one cycle after enable
  always_ff @(posedge ref_clk) active <= brownout_enable;
endmodule : supply_pin_model

// >>> tb/reset_source_and_startup_control_tb.sv
// testbench: bus-driven scenarios for the reset sequencer
// assumes STARTUP_CYCLES of 20 and a zero-wait slave
`timescale 1ns/1ps
module reset_source_and_startup_control_tb;
  import rst_pkg::*;
  logic ref_clk, rst, global_irq_enable, hwrite, hsel, hready, pin_pullup_en, hresp;
  logic external_reset_pin_in, external_reset_pin_oe, device_reset, cpu_run, bo, lp;
  logic bandgap_force_on, brownout_enable, brownout_circuit_active, hreadyout, gpio_in;
  logic [15:0] pc, restart_addr;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  cfg_s cfg;
  event_s ev, evd;
  int fails, compares, cyc, n;
  assign hready = hreadyout;
  always_comb begin
    evd = ev;
    evd.brownout_low = bo;
    evd.lp_brownout_low = lp;
  end
  reset_source_and_startup_control #(.STARTUP_CYCLES(20)) u_dut (.ref_clk, .rst, .cfg,
    .ev(evd), .global_irq_enable, .pc, .external_reset_pin_in, .external_reset_pin_out(),
    .external_reset_pin_oe, .pin_pullup_en, .gpio_in, .device_reset, .cpu_run,
    .restart_addr, .bandgap_force_on, .brownout_enable, .brownout_circuit_active,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hsel, .hready, .hrdata, .hreadyout, .hresp);
  supply_pin_model u_sup (.ref_clk, .brownout_enable, .pin(external_reset_pin_in),
    .bo_low(bo), .lp_low(lp), .active(brownout_circuit_active));
  // ****
  // tasks
  // ****
  task automatic close_out;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    haddr <= {24'h0, a};
    hwrite <= w;
    hsel <= 1'b1;
    htrans <= 2'b10;
    do @(posedge ref_clk); while (!hready);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge ref_clk); while (!hready);
    rd = hrdata;
  endtask : bus
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rd_chk
  task automatic pulse(input int i);
    @(posedge ref_clk);
    ev[i] <= 1'b1;
    @(posedge ref_clk);
    ev[i] <= 1'b0;
  endtask : pulse
  task automatic wait_run;
    n = 0;
    repeat (3) @(posedge ref_clk);
    while (cpu_run !== 1'b1 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    chk(cpu_run, 1);
  endtask : wait_run
  // ****
  // scenarios
  // ****
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 20000) begin
      fails++;
      close_out();
    end
  end
  initial begin
    rst = 1'b1;
    cfg = '0;
    ev = '0;
    ev.osc_ready = 1'b1;
    global_irq_enable = 1'b0;
    pc = 16'h0123;
    {haddr, hwdata, htrans, hwrite} = '0;
    hsize = 3'b010;
    hsel = 1'b0;
    cfg.brownout_mode_cfg = 2'b11;
    cfg.stack_fault_reset_cfg = 1'b1;
    cfg.external_pin_cfg_enable = 1'b1;
    cfg.osc_startup_required = 1'b1;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    wait_run();
    rd_chk(8'h04, 32'h1c);
    rd_chk(8'h08, 32'h18);
    rd_chk(8'h00, 32'h81);
    rd_chk(8'h20, 32'h0);
    $display("power-on test done");
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 2; s++) begin
        cfg.brownout_mode_cfg <= m[1:0];
        bus(1'b1, 8'h00, {24'h0, s[0], 7'h40});
        repeat (3) @(posedge ref_clk);
        chk(brownout_enable, m > 1 || (m == 1 && s == 1));
        chk(bandgap_force_on, m == 1 || m == 2);
      end
    end
    bus(1'b1, 8'h00, 32'h80);
    $display("mode test done");
    bus(1'b1, 8'h04, 32'h1f);
    rd_chk(8'h04, 32'h1f);
    pulse(5);
    wait_run();
    rd_chk(8'h04, 32'h1b);
    chk(restart_addr, 16'h0);
    pulse(4);
    wait_run();
    rd_chk(8'h04, 32'h9b);
    pulse(3);
    wait_run();
    rd_chk(8'h04, 32'hdb);
    pulse(6);
    wait_run();
    rd_chk(8'h04, 32'hcb);
    rd_chk(8'h08, 32'h08);
    $display("source test done");
    bus(1'b1, 8'h04, 32'h1f);
    u_sup.hold_pin(2);
    repeat (20) @(posedge ref_clk);
    rd_chk(8'h04, 32'h1f);
    u_sup.hold_pin(20);
    wait_run();
    rd_chk(8'h04, 32'h17);
    ev.sleeping <= 1'b1;
    u_sup.hold_pin(20);
    ev.sleeping <= 1'b0;
    wait_run();
    rd_chk(8'h08, 32'h10);
    $display("pin test done");
    ev.sleeping <= 1'b1;
    global_irq_enable <= 1'b1;
    pulse(6);
    repeat (3) @(posedge ref_clk);
    chk(restart_addr, 16'h0124);
    rd_chk(8'h08, 32'h00);
    pulse(2);
    repeat (3) @(posedge ref_clk);
    chk(restart_addr, 16'h0004);
    rd_chk(8'h08, 32'h10);
    pc <= 16'h0456;
    global_irq_enable <= 1'b0;
    pulse(2);
    repeat (3) @(posedge ref_clk);
    chk(restart_addr, 16'h0457);
    ev.sleeping <= 1'b0;
    $display("wake test done");
    bus(1'b1, 8'h04, 32'h1f);
    u_sup.dip(1'b1, 10);
    rd_chk(8'h04, 32'h1f);
    cfg.low_power_brownout <= 1'b1;
    u_sup.dip(1'b1, 10);
    wait_run();
    rd_chk(8'h04, 32'h1e);
    rd_chk(8'h08, 32'h18);
    bus(1'b1, 8'h04, 32'h1f);
    u_sup.dip(1'b0, 10);
    wait_run();
    rd_chk(8'h04, 32'h1e);
    $display("supply test done");
    fork
      u_sup.hold_pin(60);
    join_none
    repeat (10) @(posedge ref_clk);
    pulse(10);
    @(posedge external_reset_pin_in);
    n = 0;
    while (cpu_run !== 1'b1 && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    chk(n >= 10 && n <= 24, 1);
    rd_chk(8'h04, 32'h1c);
    bus(1'b1, 8'h04, 32'h1f);
    pulse(9);
    wait_run();
    rd_chk(8'h04, 32'h1c);
    ev.osc_ready <= 1'b0;
    pulse(10);
    repeat (40) @(posedge ref_clk);
    chk(cpu_run, 0);
    ev.osc_ready <= 1'b1;
    wait_run();
    $display("start-up test done");
    bus(1'b1, 8'h0c, 32'h0);
    for (int k = 0; k < 4; k++) begin
      cfg.low_voltage_program_cfg <= k[1];
      cfg.external_pin_cfg_enable <= k[0];
      repeat (3) @(posedge ref_clk);
      chk(pin_pullup_en, k != 0);
    end
    cfg.low_voltage_program_cfg <= 1'b0;
    cfg.external_pin_cfg_enable <= 1'b0;
    bus(1'b1, 8'h0c, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk(pin_pullup_en, 1);
    u_sup.hold_pin(20);
    #1;
    chk(gpio_in, 0);
    chk(cpu_run, 1);
    repeat (4) @(posedge ref_clk);
    #1;
    chk(gpio_in, 1);
    $display("pin config test done");
    close_out();
  end
endmodule : reset_source_and_startup_control_tb
